// [verilog/deep_sleep_clock_gate_one.sv]
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
module deep_sleep_clock_gate_one
  import clock_gate_pkg::*;
(
  input  wire logic                 CLOCK,          // System clock, 100 MHz
  input  wire logic                 RST,            // Synchronous reset, active high
  input  wire logic                 PSEL,           // APB select
  input  wire logic                 PENABLE,        // APB access phase
  input  wire logic                 PWRITE,         // APB write
  input  wire logic [11:0]          PADDR,          // APB byte address
  input  wire logic [31:0]          PWDATA,         // APB write data
  output logic      [31:0]          PRDATA,         // APB read data
  output logic                      PREADY,         // APB ready
  output logic                      PSLVERR,        // APB error, unmapped address
  input  wire logic                 SLEEP_REQ,      // Processor in sleep
  input  wire logic                 DEEP_SLEEP_REQ, // Processor in deep-sleep
  input  wire logic [NUM_GATES-1:0] PERIPH_ACCESS,  // Access strobe per peripheral
  output logic      [NUM_GATES-1:0] PERIPH_CLK,     // Gated peripheral clocks
  output logic      [NUM_GATES-1:0] PERIPH_EN,      // Peripheral enable levels
  output logic                      BUS_FAULT,      // Fault pulse for gated access
  output logic                      IRQ             // Unmasked fault interrupt
);

  apb_req_type        req;
  reg_sel_type        reg_sel;
  power_mode_type     mode_q;
  power_mode_type     mode_d;
  logic [31:0]        run_gate_q;
  logic [31:0]        sleep_gate_q;
  logic [31:0]        deep_gate_q;
  logic [31:0]        config_q;
  logic [31:0]        status_q;
  logic [31:0]        mask_q;
  logic [31:0]        applied_gate;
  logic [31:0]        applied_gate_q;
  logic [31:0]        fault_set;
  logic [31:0]        status_clear;
  logic [31:0]        state_word;
  logic [31:0]        prdata_d;
  logic               pslverr_d;
  logic               setup_phase;
  logic               write_commit;
  logic               auto_gating;
  logic [NUM_GATES-1:0] fault_hit;
  logic               bus_fault_q;

  // Bundle the bus request
  assign req = '{
    sel:    PSEL,
    enable: PENABLE,
    write:  PWRITE,
    addr:   PADDR,
    wdata:  PWDATA
  };

  // Zero wait state slave
  assign PREADY = 1'b1;

  // Phase qualifiers
  assign setup_phase  = req.sel & ~req.enable;
  assign write_commit = req.sel & req.enable & req.write;

  // Address decode
  always_comb begin
    if (req.addr == RUN_CLOCK_GATE_ONE_OFS) begin
      reg_sel = SEL_RUN;
    end else if (req.addr == SLEEP_CLOCK_GATE_ONE_OFS) begin
      reg_sel = SEL_SLEEP;
    end else if (req.addr == DEEP_SLEEP_CLOCK_GATE_ONE_OFS) begin
      reg_sel = SEL_DEEP;
    end else if (req.addr == RUN_CLOCK_CONFIG_OFS) begin
      reg_sel = SEL_CONFIG;
    end else if (req.addr == FAULT_STATUS_OFS) begin
      reg_sel = SEL_STATUS;
    end else if (req.addr == FAULT_MASK_OFS) begin
      reg_sel = SEL_MASK;
    end else if (req.addr == GATE_STATE_OFS) begin
      reg_sel = SEL_STATE;
    end else begin
      reg_sel = SEL_NONE;
    end
  end

  // Auto gating switch of the run configuration
  assign auto_gating = config_q[POS_AUTO_SLEEP_GATING_ENABLE];

  // Power mode follows the request lines
  always_comb begin
    mode_d = mode_q;
    case (mode_q)
      MODE_RUN: begin
        if (auto_gating && DEEP_SLEEP_REQ) begin
          mode_d = MODE_DEEP;
        end else if (auto_gating && SLEEP_REQ) begin
          mode_d = MODE_SLEEP;
        end
      end
      MODE_SLEEP: begin
        // Deep-sleep request wins over sleep, straight from sleep
        if (!auto_gating) begin
          mode_d = MODE_RUN;
        end else if (DEEP_SLEEP_REQ) begin
          mode_d = MODE_DEEP;
        end else if (!SLEEP_REQ) begin
          mode_d = MODE_RUN;
        end
      end
      MODE_DEEP: begin
        if (!auto_gating || !DEEP_SLEEP_REQ) begin
          mode_d = MODE_RUN;
        end
      end
      default: begin
        mode_d = MODE_RUN;
      end
    endcase
  end

  // Mode register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mode_q <= MODE_RUN;
    end else begin
      mode_q <= mode_d;
    end
  end

  // Run mode gate register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      run_gate_q <= GATE_RESET;
    end else if (write_commit && reg_sel == SEL_RUN) begin
      run_gate_q <= req.wdata & GATE_WRITE_MASK;
    end
  end

  // Sleep mode gate register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      sleep_gate_q <= GATE_RESET;
    end else if (write_commit && reg_sel == SEL_SLEEP) begin
      sleep_gate_q <= req.wdata & GATE_WRITE_MASK;
    end
  end

  // Deep-sleep gate register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      deep_gate_q <= GATE_RESET;
    end else if (write_commit && reg_sel == SEL_DEEP) begin
      // Bits 25,24,18,17,16,4,0 writable, rest stay zero
      deep_gate_q <= req.wdata & GATE_WRITE_MASK;
    end
  end

  // Run clock configuration register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      config_q <= CONFIG_RESET;
    end else if (write_commit && reg_sel == SEL_CONFIG) begin
      config_q <= '0;
      config_q[POS_AUTO_SLEEP_GATING_ENABLE] <= req.wdata[POS_AUTO_SLEEP_GATING_ENABLE];
    end
  end

  // Fault interrupt mask register
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      mask_q <= STATUS_RESET;
    end else if (write_commit && reg_sel == SEL_MASK) begin
      mask_q <= req.wdata & GATE_WRITE_MASK;
    end
  end

  // Gate register chosen by the current mode
  always_comb begin
    case (mode_q)
      MODE_SLEEP: applied_gate = sleep_gate_q;
      MODE_DEEP:  applied_gate = deep_gate_q;
      default:    applied_gate = run_gate_q;
    endcase
  end

  // Registered gate vector, changes only at rising edges
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      applied_gate_q <= GATE_RESET;
    end else begin
      applied_gate_q <= applied_gate;
    end
  end

  // Per peripheral gating and fault detection
  genvar g;
  generate
    for (g = 0; g < NUM_GATES; g = g + 1) begin : gen_gate
      glitchless_clock_gate u_gate (
        .clk_in  (CLOCK),
        .enable  (applied_gate_q[GATE_POS[g]]),
        .clk_out (PERIPH_CLK[g])
      );
      assign PERIPH_EN[g] = applied_gate_q[GATE_POS[g]];
      assign fault_hit[g] = PERIPH_ACCESS[g] & ~applied_gate_q[GATE_POS[g]];
    end
  endgenerate

  // Spread per peripheral faults onto register bit positions
  always_comb begin
    fault_set = '0;
    for (int i = 0; i < NUM_GATES; i++) begin
      fault_set[GATE_POS[i]] = fault_hit[i];
    end
  end

  // Write one to clear status bits
  assign status_clear = (write_commit && reg_sel == SEL_STATUS) ?
                        (req.wdata & GATE_WRITE_MASK) : '0;

  // Sticky fault status, a new fault beats a clear
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= (status_q & ~status_clear) | fault_set;
    end
  end

  // Bus fault pulse to the requesting master
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      bus_fault_q <= 1'b0;
    end else begin
      bus_fault_q <= |fault_hit;
    end
  end

  assign BUS_FAULT = bus_fault_q;

  // Level interrupt for unmasked faults
  assign IRQ = |(status_q & mask_q);

  // Gate state word: applied gates plus mode
  always_comb begin
    state_word = applied_gate_q;
    state_word[POS_MODE_FIELD +: 2] = mode_q;
  end

  // Read data mux
  always_comb begin
    prdata_d  = '0;
    pslverr_d = 1'b0;
    if (reg_sel == SEL_RUN) begin
      prdata_d = run_gate_q;
    end else if (reg_sel == SEL_SLEEP) begin
      prdata_d = sleep_gate_q;
    end else if (reg_sel == SEL_DEEP) begin
      prdata_d = deep_gate_q;
    end else if (reg_sel == SEL_CONFIG) begin
      prdata_d = config_q;
    end else if (reg_sel == SEL_STATUS) begin
      prdata_d = status_q;
    end else if (reg_sel == SEL_MASK) begin
      prdata_d = mask_q;
    end else if (reg_sel == SEL_STATE) begin
      prdata_d = state_word;
    end else begin
      pslverr_d = 1'b1;
    end
  end

  // Capture read data and error during setup phase
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end else if (setup_phase) begin
      PRDATA  <= req.write ? 32'h0000_0000 : prdata_d;
      PSLVERR <= pslverr_d;
    end else if (!req.sel) begin
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
  end

endmodule

// [verilog/clock_gate_pkg.sv]
package clock_gate_pkg;

  // Number of gated peripherals
  localparam int unsigned NUM_GATES = 7;

  // Register byte offsets
  localparam logic [11:0] RUN_CLOCK_GATE_ONE_OFS        = 12'h104;
  localparam logic [11:0] SLEEP_CLOCK_GATE_ONE_OFS      = 12'h114;
  localparam logic [11:0] DEEP_SLEEP_CLOCK_GATE_ONE_OFS = 12'h124;
  localparam logic [11:0] RUN_CLOCK_CONFIG_OFS          = 12'h130;
  localparam logic [11:0] FAULT_STATUS_OFS              = 12'h134;
  localparam logic [11:0] FAULT_MASK_OFS                = 12'h138;
  localparam logic [11:0] GATE_STATE_OFS                = 12'h13c;

  // Gate bit positions, index order of the peripheral vectors
  localparam int unsigned POS_ASYNC_SERIAL_A = 0;
  localparam int unsigned POS_SYNC_SERIAL_A  = 4;
  localparam int unsigned POS_GP_COUNTER_A   = 16;
  localparam int unsigned POS_GP_COUNTER_B   = 17;
  localparam int unsigned POS_GP_COUNTER_C   = 18;
  localparam int unsigned POS_ANALOG_CMP_A   = 24;
  localparam int unsigned POS_ANALOG_CMP_B   = 25;
  localparam int unsigned GATE_POS [NUM_GATES] = '{
    POS_ASYNC_SERIAL_A, POS_SYNC_SERIAL_A, POS_GP_COUNTER_A, POS_GP_COUNTER_B,
    POS_GP_COUNTER_C, POS_ANALOG_CMP_A, POS_ANALOG_CMP_B};

  // Writable bits of the gate, status and mask registers
  localparam logic [31:0] GATE_WRITE_MASK = 32'h0307_0011;

  // Auto sleep gating enable bit in run_clock_config
  localparam int unsigned POS_AUTO_SLEEP_GATING_ENABLE = 0;

  // Gate state register: mode field position
  localparam int unsigned POS_MODE_FIELD = 30;

  // Reset values
  localparam logic [31:0] GATE_RESET   = 32'h0000_0000;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0000;
  localparam logic [31:0] STATUS_RESET = 32'h0000_0000;

  // Applied power mode
  typedef enum logic [1:0] {
    MODE_RUN,
    MODE_SLEEP,
    MODE_DEEP
  } power_mode_type;

  // Register selected by the current address
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_RUN,
    SEL_SLEEP,
    SEL_DEEP,
    SEL_CONFIG,
    SEL_STATUS,
    SEL_MASK,
    SEL_STATE
  } reg_sel_type;

  // One APB request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } apb_req_type;

endpackage

// [verilog/glitchless_clock_gate.sv]
`timescale 1ns/1ns
module glitchless_clock_gate (
  input  wire logic clk_in,   // Free running clock
  input  wire logic enable,   // Gate enable from clock domain
  output logic      clk_out   // Gated clock
);

  logic enable_l;

  // Enable only passes while clock is low
  always_latch begin
    if (!clk_in) begin
      enable_l = enable;
    end
  end

  // Clock passes only with latched enable
  assign clk_out = clk_in & enable_l;

endmodule

// [testbench/clock_gate_props.sv]
`timescale 1ns/1ns
module clock_gate_props
  import clock_gate_pkg::*;
(
  input wire logic                 CLOCK,          // Clock
  input wire logic                 RST,            // Reset
  input wire logic                 PSEL,           // Select
  input wire logic                 PENABLE,        // Access
  input wire logic                 PWRITE,         // Write
  input wire logic [11:0]          PADDR,          // Address
  input wire logic [31:0]          PWDATA,         // Write data
  input wire logic [31:0]          PRDATA,         // Read data
  input wire logic                 PREADY,         // Ready
  input wire logic                 PSLVERR,        // Error
  input wire logic                 SLEEP_REQ,      // Sleep
  input wire logic                 DEEP_SLEEP_REQ, // Deep sleep
  input wire logic [NUM_GATES-1:0] PERIPH_ACCESS,  // Strobes
  input wire logic [NUM_GATES-1:0] PERIPH_CLK,     // Clocks
  input wire logic [NUM_GATES-1:0] PERIPH_EN,      // Enables
  input wire logic                 BUS_FAULT,      // Fault
  input wire logic                 IRQ             // Interrupt
);
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RST);
  // Helper terms
  wire logic       gated = |(PERIPH_ACCESS & ~PERIPH_EN);
  wire logic       acc = PSEL && PENABLE;
  wire logic [6:0] run_bits = {PWDATA[25:24], PWDATA[18:16], PWDATA[4], PWDATA[0]};
  wire logic       mapped = PADDR inside {RUN_CLOCK_GATE_ONE_OFS, SLEEP_CLOCK_GATE_ONE_OFS,
    DEEP_SLEEP_CLOCK_GATE_ONE_OFS, RUN_CLOCK_CONFIG_OFS, FAULT_STATUS_OFS, FAULT_MASK_OFS,
    GATE_STATE_OFS};
  wire logic       gate_rd = !PWRITE && PADDR inside {RUN_CLOCK_GATE_ONE_OFS,
    SLEEP_CLOCK_GATE_ONE_OFS, DEEP_SLEEP_CLOCK_GATE_ONE_OFS};

  fault_raise_a: assert property (gated |=> BUS_FAULT)
    else $error("gated access gave no fault");
  fault_cause_a: assert property (BUS_FAULT |-> $past(gated))
    else $error("fault without gated access");
  clk_follow_a: assert property (@(negedge CLOCK) disable iff (RST)
    PERIPH_CLK == $past(PERIPH_EN))
    else $error("gated clock wrong");
  ready_high_a: assert property (acc |-> PREADY)
    else $error("ready low");
  write_zero_a: assert property (PSEL && !PENABLE && PWRITE |=> PRDATA == 32'h0)
    else $error("read data on write");
  reserved_zero_a: assert property (acc && gate_rd |-> (PRDATA & ~GATE_WRITE_MASK) == 32'h0)
    else $error("reserved bit set");
  slverr_map_a: assert property (acc |-> PSLVERR == !mapped)
    else $error("error flag wrong");
  run_apply_a: assert property ((!SLEEP_REQ && !DEEP_SLEEP_REQ)[*3] ##0 (acc && PWRITE &&
    PADDR == RUN_CLOCK_GATE_ONE_OFS) |=> ##1 PERIPH_EN == $past(run_bits, 2))
    else $error("run gates not applied");
endmodule

bind deep_sleep_clock_gate_one clock_gate_props i_props (.*);

// [testbench/testbench.sv]
`timescale 1ns/1ns
module testbench
  import clock_gate_pkg::*;
;
  logic        CLOCK, RST, PSEL, PENABLE, PWRITE, SLEEP_REQ, DEEP_SLEEP_REQ, PREADY;
  logic        PSLVERR, BUS_FAULT, IRQ, err;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, seed, rd, v, r, s, d, e;
  logic [6:0]  PERIPH_ACCESS, PERIPH_CLK, PERIPH_EN;
  int          failures, tests_run;
  localparam logic [11:0] OFFS [7] = '{RUN_CLOCK_GATE_ONE_OFS, SLEEP_CLOCK_GATE_ONE_OFS,
    DEEP_SLEEP_CLOCK_GATE_ONE_OFS, RUN_CLOCK_CONFIG_OFS, FAULT_STATUS_OFS, FAULT_MASK_OFS,
    GATE_STATE_OFS};

  deep_sleep_clock_gate_one i_dut (.*);

  // Clock
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // Random step
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    for (int i = 0; i < 32; i++)
      x = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    return x;
  endfunction

  // Enables expected from a gate word
  function automatic logic [6:0] gates(input logic [31:0] x);
    for (int i = 0; i < NUM_GATES; i++)
      gates[i] = x[GATE_POS[i]];
  endfunction

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // One APB transfer, then an idle cycle
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] x);
    int n;
    n = 0;
    PSEL    <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE  <= w;
    PADDR   <= a;
    PWDATA  <= x;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do begin
      @(posedge CLOCK);
      n++;
    end while (PREADY !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      final_report();
    end
    rd  = PRDATA;
    err = PSLVERR;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLOCK);
  endtask

  // Hang guard
  initial begin
    #300000;
    failures++;
    final_report();
  end

  initial begin
    {RST, PSEL, PENABLE, PWRITE, SLEEP_REQ, DEEP_SLEEP_REQ} = 6'h20;
    {PADDR, PWDATA, PERIPH_ACCESS} = '0;
    {failures, tests_run} = '0;
    seed = 32'hea08ac57;
    repeat (8) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    // Reset values
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, OFFS[i], 32'h0);
      check(rd, 32'h0);
    end
    check({25'h0, PERIPH_EN}, 32'h0);
    $display("reset test done");
    // Gate registers, reserved bits, unmapped place
    for (int k = 0; k < 12; k++) begin
      seed = lfsr(seed);
      v = (k < 3) ? 32'hffff_ffff : seed;
      apb(1'b1, OFFS[k % 3], v);
      apb(1'b0, OFFS[k % 3], 32'h0);
      check(rd, v & GATE_WRITE_MASK);
    end
    apb(1'b1, 12'h200, 32'hffff_ffff);
    apb(1'b0, 12'h200, 32'h0);
    check({err, rd}, {1'b1, 32'h0});
    apb(1'b1, RUN_CLOCK_CONFIG_OFS, 32'hffff_ffff);
    apb(1'b0, RUN_CLOCK_CONFIG_OFS, 32'h0);
    check(rd, 32'h1);
    $display("register test done");
    // Faults on gated peripherals, interrupt mask and clear
    apb(1'b1, RUN_CLOCK_CONFIG_OFS, 32'h0);
    apb(1'b1, RUN_CLOCK_GATE_ONE_OFS, 32'h0);
    apb(1'b1, FAULT_MASK_OFS, GATE_WRITE_MASK & ~32'h1);
    for (int i = 0; i < NUM_GATES; i++) begin
      PERIPH_ACCESS <= 7'(1 << i);
      @(posedge CLOCK);
      PERIPH_ACCESS <= 7'h0;
      @(negedge CLOCK);
      check({30'h0, BUS_FAULT, IRQ}, {30'h0, 1'b1, i != 0});
      @(posedge CLOCK);
      apb(1'b0, FAULT_STATUS_OFS, 32'h0);
      check(rd, 32'h1 << GATE_POS[i]);
      apb(1'b1, FAULT_STATUS_OFS, 32'h1 << GATE_POS[i]);
      apb(1'b0, FAULT_STATUS_OFS, 32'h0);
      check({rd[30:0], IRQ}, 32'h0);
    end
    apb(1'b1, RUN_CLOCK_GATE_ONE_OFS, GATE_WRITE_MASK);
    PERIPH_ACCESS <= 7'h7f;
    @(posedge CLOCK);
    PERIPH_ACCESS <= 7'h0;
    @(negedge CLOCK);
    check({24'h0, BUS_FAULT, PERIPH_EN}, 32'h7f);
    @(posedge CLOCK);
    $display("fault test done");
    // Register applied per power mode and auto gating bit
    r = lfsr(seed);
    s = lfsr(r);
    d = lfsr(s);
    apb(1'b1, RUN_CLOCK_GATE_ONE_OFS, r);
    apb(1'b1, SLEEP_CLOCK_GATE_ONE_OFS, s);
    apb(1'b1, DEEP_SLEEP_CLOCK_GATE_ONE_OFS, d);
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, RUN_CLOCK_CONFIG_OFS, {31'h0, c[2]});
      SLEEP_REQ      <= c[0];
      DEEP_SLEEP_REQ <= c[1];
      repeat (4) @(posedge CLOCK);
      e = (!c[2] || c[1:0] == 2'd0) ? r : (c[1:0] == 2'd1) ? s : d;
      @(negedge CLOCK);
      check({25'h0, PERIPH_EN}, {25'h0, gates(e)});
      @(posedge CLOCK);
      apb(1'b0, GATE_STATE_OFS, 32'h0);
      check(rd & GATE_WRITE_MASK, e & GATE_WRITE_MASK);
    end
    $display("mode test done");
    // Reset in mid-run
    RST <= 1'b1;
    repeat (2) @(posedge CLOCK);
    RST <= 1'b0;
    @(posedge CLOCK);
    check({25'h0, PERIPH_EN}, 32'h0);
    apb(1'b0, DEEP_SLEEP_CLOCK_GATE_ONE_OFS, 32'h0);
    check(rd, 32'h0);
    $display("second reset test done");
    final_report();
  end
endmodule
